/* misc_status_pkg.sv */
// package: register map, reset values and types of the misc status bank
`default_nettype none
package misc_status_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_SCAN_CODE = 6'h11;
	localparam logic [5:0] IDX_FAN1_LOW = 6'h12;
	localparam logic [5:0] IDX_FAN1_HIGH = 6'h13;
	localparam logic [5:0] IDX_FAN2_LOW = 6'h14;
	localparam logic [5:0] IDX_FAN2_HIGH = 6'h15;
	localparam logic [5:0] IDX_WAKE_CTRL = 6'h16;
	localparam logic [5:0] IDX_EDGE_STATUS = 6'h17;
	localparam logic [5:0] IDX_EDGE_MASK = 6'h20;
	localparam int ADDR_LSB = 2;

	// field positions of the wake output control register
	localparam int WAKE_INVERT_BIT = 1;
	localparam int WAKE_PG_SEL_BIT = 2;
	localparam int WAKE_LOCK_BIT = 3;
	localparam int WAKE_OD_BIT = 7;

	// reset values
	localparam logic [7:0] SCAN_CODE_RESET = 8'h00;
	localparam logic [7:0] WAKE_CTRL_RESET = 8'h84;
	localparam logic [1:0] EDGE_STATUS_RESET = 2'h0;
	localparam logic [1:0] EDGE_MASK_RESET = 2'h0;
	localparam int PG_DELAY_CYCLES_DEFAULT = 16;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic openDrain;
		logic powerGoodLock;
		logic powerGoodDelaySelect;
		logic invert;
	} wake_ctrl_t;

	typedef struct packed {
		logic [15:0] fanSpeed2;
		logic [15:0] fanSpeed1;
	} fan_readings_t;

	typedef enum logic [1:0] {
		WR_COLLECT,
		WR_RESPOND
	} wr_state_t;
endpackage
`default_nettype wire

/* runtime_misc_status_control_regs.sv */
// runtime misc status/control register bank behind an AXI4-Lite slave
// Summary of operation
// - An 8-bit read/write scan code register, bit 0 the code LSB, resets to zero.
// - A read-only register returns bits 7..0 of fan speed input 1's reading.
// - A read-only register returns bits 15..8 of fan speed input 1's reading.
// - A read-only register returns bits 7..0 of fan speed input 2's reading.
// - A read-only register returns bits 15..8 of fan speed input 2's reading.
// - Wake control bit 1 set inverts the wake event output polarity.
// - Wake control bit 2 picks the delayed power good (1, default) or the undelayed synchronised one (0).
// - Writing one to bit 3 locks bits 2 and 3 until the next power-on reset.
// - Wake control bit 7 picks open-drain (1, default) or push-pull drive.
// - Edge status bits 1..0 clear only on a written one; a zero does nothing.
// - Either edge on edge interrupt pin 0 sets status bit 0.
// - Either edge on edge interrupt pin 1 sets status bit 1.
// - Status bits 7..2 always read as zero.
`default_nettype none
module runtime_misc_status_control_regs
	import misc_status_pkg::*;
#(
	parameter int PG_DELAY_CYCLES = PG_DELAY_CYCLES_DEFAULT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// fan measurements from the tachometer logic, same clock
	input wire fan_readings_t fanReadings,
	// wake event request from the wake logic, same clock, active high
	input wire logic wakeRequest,
	// wake event output pin, open-drain or push-pull
	output logic wakeEventOut,
	output logic wakeEventOe,
	// platform power good pin and the selected output
	input wire logic platformPowerGood,
	output logic powerGoodOut,
	// edge interrupt pins
	input wire logic edgeInterruptPin0,
	input wire logic edgeInterruptPin1,
	// interrupt
	output logic irq
);

	function automatic logic isMapped(input logic [5:0] idx);
		case (idx)
			IDX_SCAN_CODE, IDX_FAN1_LOW, IDX_FAN1_HIGH, IDX_FAN2_LOW,
			IDX_FAN2_HIGH, IDX_WAKE_CTRL, IDX_EDGE_STATUS,
			IDX_EDGE_MASK: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction

	// register state
	logic [7:0] scanCode_q;
	wake_ctrl_t wakeCtrl_q;
	logic [1:0] edgeStatus_q;
	logic [1:0] edgeStatus_d;
	logic [1:0] edgeMask_q;

	// bus state
	wr_state_t wrState_q;
	logic awHeld_q;
	logic wHeld_q;
	logic [5:0] wrIdx_q;
	logic [31:0] wrData_q;
	logic wrLane0_q;
	logic wrCommit;

	// pin synchronisers and edge detection
	logic [1:0] edgeSync1_q;
	logic [1:0] edgeSync2_q;
	logic [1:0] edgePrev_q;
	logic [1:0] edgeSeen;
	logic pgSync1_q;
	logic pgSync2_q;
	logic pgDelayed_q;
	logic [$clog2(PG_DELAY_CYCLES+1)-1:0] pgCount_q;

	// wake pin and read address decode
	logic wakePinLevel;
	logic [5:0] rdIdx;

	// byte address to register index; the low two bits only pick a lane
	function automatic logic [5:0] wordIndex(input logic [7:0] addr);
		wordIndex = addr[ADDR_LSB+5:ADDR_LSB];
	endfunction

	// a committed write that carries byte lane 0 into register idx
	function automatic logic writesTo(input logic [5:0] idx);
		writesTo = wrCommit && wrLane0_q && (wrIdx_q == idx);
	endfunction

	// write channel: address and data taken in either order
	assign wrCommit = (wrState_q == WR_COLLECT) && awHeld_q && wHeld_q;
	assign rdIdx = wordIndex(s_axi_araddr);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			awHeld_q <= 1'b0;
			wrIdx_q <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_q <= 1'b1;
			// held until the response so bresp sees the address as taken
			wrIdx_q <= wordIndex(s_axi_awaddr);
		end else if (s_axi_bvalid && s_axi_bready) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wHeld_q <= 1'b0;
			wrData_q <= 32'h0000_0000;
			wrLane0_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_q <= 1'b1;
			wrData_q <= s_axi_wdata;
			wrLane0_q <= s_axi_wstrb[0];
		end else if (s_axi_bvalid && s_axi_bready) begin
			wHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrState_q <= WR_COLLECT;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wrState_q)
				WR_COLLECT: begin
					if (wrCommit) begin
						wrState_q <= WR_RESPOND;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= isMapped(wrIdx_q) ? RESP_OKAY : RESP_SLVERR;
					end
				end
				WR_RESPOND: begin
					if (s_axi_bready) begin
						wrState_q <= WR_COLLECT;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					// no other encoding is reachable; fall back to idle
					wrState_q <= WR_COLLECT;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// scan code register; only byte lane 0 carries data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scanCode_q <= SCAN_CODE_RESET;
		end else if (writesTo(IDX_SCAN_CODE)) begin
			scanCode_q <= wrData_q[7:0];
		end
	end

	// wake control; lock is only released by reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wakeCtrl_q.invert <= WAKE_CTRL_RESET[WAKE_INVERT_BIT];
			wakeCtrl_q.powerGoodDelaySelect <= WAKE_CTRL_RESET[WAKE_PG_SEL_BIT];
			wakeCtrl_q.powerGoodLock <= WAKE_CTRL_RESET[WAKE_LOCK_BIT];
			wakeCtrl_q.openDrain <= WAKE_CTRL_RESET[WAKE_OD_BIT];
		end else if (writesTo(IDX_WAKE_CTRL)) begin
			wakeCtrl_q.invert <= wrData_q[WAKE_INVERT_BIT];
			wakeCtrl_q.openDrain <= wrData_q[WAKE_OD_BIT];
			if (!wakeCtrl_q.powerGoodLock) begin
				wakeCtrl_q.powerGoodDelaySelect <= wrData_q[WAKE_PG_SEL_BIT];
				wakeCtrl_q.powerGoodLock <= wrData_q[WAKE_LOCK_BIT];
			end
		end
	end

	// edge interrupt mask
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			edgeMask_q <= EDGE_MASK_RESET;
		end else if (writesTo(IDX_EDGE_MASK)) begin
			edgeMask_q <= wrData_q[1:0];
		end
	end

	// edge pin synchronisers; first stage feeds only the second
	// pins idle low; one held high through reset reports an edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			edgeSync1_q <= 2'b00;
			edgeSync2_q <= 2'b00;
			edgePrev_q <= 2'b00;
		end else begin
			edgeSync1_q <= {edgeInterruptPin1, edgeInterruptPin0};
			edgeSync2_q <= edgeSync1_q;
			edgePrev_q <= edgeSync2_q;
		end
	end

	// any change between samples is an edge, rising or falling
	assign edgeSeen = edgeSync2_q ^ edgePrev_q;

	// edge status: write-one-to-clear, a new edge beats the clear
	always_comb begin
		edgeStatus_d = edgeStatus_q;
		if (writesTo(IDX_EDGE_STATUS)) begin
			edgeStatus_d = edgeStatus_q & ~wrData_q[1:0];
		end
		edgeStatus_d[0] = edgeStatus_d[0] | edgeSeen[0];
		edgeStatus_d[1] = edgeStatus_d[1] | edgeSeen[1];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			edgeStatus_q <= EDGE_STATUS_RESET;
		end else begin
			edgeStatus_q <= edgeStatus_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			// next status, so irq rises together with the status bit
			irq <= |(edgeStatus_d & edgeMask_q);
		end
	end

	// read channel; one read in flight, answer the cycle after the address
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			// fan words are read live; a carry between halves is not hidden
			s_axi_rdata <= readWord(rdIdx);
			if (isMapped(rdIdx)) begin
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	// read mux; reserved bits and unmapped words read as zero
	function automatic logic [31:0] readWord(input logic [5:0] idx);
		readWord = 32'h0000_0000;
		case (idx)
			IDX_SCAN_CODE: readWord[7:0] = scanCode_q;
			IDX_FAN1_LOW: readWord[7:0] = fanReadings.fanSpeed1[7:0];
			IDX_FAN1_HIGH: readWord[7:0] = fanReadings.fanSpeed1[15:8];
			IDX_FAN2_LOW: readWord[7:0] = fanReadings.fanSpeed2[7:0];
			IDX_FAN2_HIGH: readWord[7:0] = fanReadings.fanSpeed2[15:8];
			IDX_WAKE_CTRL: begin
				// bits 0 and 6..4 are reserved and read as zero
				readWord[WAKE_INVERT_BIT] = wakeCtrl_q.invert;
				readWord[WAKE_PG_SEL_BIT] = wakeCtrl_q.powerGoodDelaySelect;
				readWord[WAKE_LOCK_BIT] = wakeCtrl_q.powerGoodLock;
				readWord[WAKE_OD_BIT] = wakeCtrl_q.openDrain;
			end
			IDX_EDGE_STATUS: readWord[1:0] = edgeStatus_q;
			IDX_EDGE_MASK: readWord[1:0] = edgeMask_q;
			default: readWord = 32'h0000_0000;
		endcase
	endfunction

	// wake pin: asserted level is low unless inverted
	assign wakePinLevel = wakeRequest ~^ wakeCtrl_q.invert;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wakeEventOut <= 1'b0;
			wakeEventOe <= 1'b0;
		end else if (wakeCtrl_q.openDrain) begin
			// open drain only ever pulls low; high comes from the pull-up
			wakeEventOut <= 1'b0;
			wakeEventOe <= ~wakePinLevel;
		end else begin
			wakeEventOut <= wakePinLevel;
			wakeEventOe <= 1'b1;
		end
	end

	// platform power good synchroniser
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pgSync1_q <= 1'b0;
			pgSync2_q <= 1'b0;
		end else begin
			pgSync1_q <= platformPowerGood;
			pgSync2_q <= pgSync1_q;
		end
	end

	// delayed copy: rises after a steady high, falls at once
	// counter stops at the limit, so a long high never wraps
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pgCount_q <= '0;
			pgDelayed_q <= 1'b0;
		end else if (!pgSync2_q) begin
			pgCount_q <= '0;
			pgDelayed_q <= 1'b0;
		end else if (pgCount_q == PG_DELAY_CYCLES[$bits(pgCount_q)-1:0]) begin
			pgDelayed_q <= 1'b1;
		end else begin
			pgCount_q <= pgCount_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			powerGoodOut <= 1'b0;
		end else if (wakeCtrl_q.powerGoodDelaySelect) begin
			powerGoodOut <= pgDelayed_q;
		end else begin
			powerGoodOut <= pgSync2_q;
		end
	end

endmodule
`default_nettype wire

/* misc_status_asserts.sv */
// checker: bus handshakes, wake pin and power good timing
`default_nettype none
module misc_status_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic wakeEventOut,
	input wire logic wakeEventOe,
	input wire logic platformPowerGood,
	input wire logic powerGoodOut
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late b");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("late r");
	chk_wr_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write reopened");
	chk_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read reopened");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
		else $error("upper rdata set");
	chk_od_release: assert property (!wakeEventOe |-> !wakeEventOut)
		else $error("released pin high");
	chk_pg_fall: assert property (!platformPowerGood [*5] |=> !powerGoodOut)
		else $error("power good stuck");
endmodule
bind runtime_misc_status_control_regs misc_status_asserts i_chk (
	.sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.wakeEventOut, .wakeEventOe, .platformPowerGood, .powerGoodOut
);
`default_nettype wire

/* runtime_misc_status_control_regs_tb.sv */
// testbench: register bus sequences for the misc status bank
`default_nettype none
module runtime_misc_status_control_regs_tb import misc_status_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PG_DLY = 4;
	logic sys_clk = 1'b0, rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	fan_readings_t fanReadings = '0;
	logic wakeRequest = 1'b0, platformPowerGood = 1'b0;
	logic edgeInterruptPin0 = 1'b0, edgeInterruptPin1 = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, wakeEventOut, wakeEventOe, powerGoodOut, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int fail_count = 0, check_count = 0, cycles = 0;
	logic [7:0] ctl;
	logic lvl;

	runtime_misc_status_control_regs #(.PG_DELAY_CYCLES(PG_DLY)) i_dut (
		.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .fanReadings, .wakeRequest,
		.wakeEventOut, .wakeEventOe, .platformPowerGood, .powerGoodOut,
		.edgeInterruptPin0, .edgeInterruptPin1, .irq
	);

	initial forever #20 sys_clk = ~sys_clk;

	task automatic conclude();
		if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d,
		input logic [1:0] rsp = RESP_OKAY);
		logic aDone, wDone;
		aDone = 1'b0;
		wDone = 1'b0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// address and data may be taken at different edges
		while (!(aDone && wDone)) begin
			@(posedge sys_clk);
			if (s_axi_awready && !aDone) begin
				aDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !wDone) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		chk("bresp", 32'(rsp), 32'(s_axi_bresp));
		s_axi_bready <= 1'b0;
		// idle edge: a following call never reassigns ready in this step
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] d,
		input logic [1:0] rsp = RESP_OKAY);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		chk("rdata", {24'h0, d}, s_axi_rdata);
		chk("rresp", 32'(rsp), 32'(s_axi_rresp));
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic doReset();
		rstn <= 1'b0;
		tick(10);
		rstn <= 1'b1;
		tick(1);
	endtask

	initial begin
		doReset();
		rd(IDX_SCAN_CODE, SCAN_CODE_RESET);
		rd(IDX_WAKE_CTRL, WAKE_CTRL_RESET);
		rd(IDX_EDGE_STATUS, 8'h00);
		wr(IDX_SCAN_CODE, 8'ha5);
		rd(IDX_SCAN_CODE, 8'ha5);
		// lane 0 not strobed: write answered but ignored
		s_axi_wstrb <= 4'h0;
		wr(IDX_SCAN_CODE, 8'h5a);
		s_axi_wstrb <= 4'hf;
		rd(IDX_SCAN_CODE, 8'ha5);
		fanReadings <= {16'hc3a5, 16'h5a3c};
		rd(IDX_FAN1_LOW, 8'h3c);
		rd(IDX_FAN1_HIGH, 8'h5a);
		rd(IDX_FAN2_LOW, 8'ha5);
		rd(IDX_FAN2_HIGH, 8'hc3);
		wr(6'h30, 8'h11, RESP_SLVERR);
		rd(6'h30, 8'h00, RESP_SLVERR);
		// every drive type, polarity and request level
		for (int i = 0; i < 8; i++) begin
			ctl = {i[2], 3'b000, 1'b0, 1'b1, i[1], 1'b0};
			wr(IDX_WAKE_CTRL, ctl);
			rd(IDX_WAKE_CTRL, ctl);
			wakeRequest <= i[0];
			tick(2);
			lvl = ~(i[0] ^ i[1]);
			chk("wakeOe", 32'(i[2] ? !lvl : 1'b1), 32'(wakeEventOe));
			chk("wakeOut", 32'(i[2] ? 1'b0 : lvl), 32'(wakeEventOut));
		end
		wakeRequest <= 1'b0;
		platformPowerGood <= 1'b1;
		tick(6);
		chk("pgEarly", 32'h0, 32'(powerGoodOut));
		tick(PG_DLY + 8);
		chk("pgDelayed", 32'h1, 32'(powerGoodOut));
		platformPowerGood <= 1'b0;
		tick(6);
		wr(IDX_WAKE_CTRL, 8'h80);
		platformPowerGood <= 1'b1;
		tick(6);
		chk("pgDirect", 32'h1, 32'(powerGoodOut));
		platformPowerGood <= 1'b0;
		wr(IDX_WAKE_CTRL, 8'h88);
		wr(IDX_WAKE_CTRL, 8'h04);
		rd(IDX_WAKE_CTRL, 8'h08);
		wr(IDX_EDGE_MASK, 8'h03);
		edgeInterruptPin0 <= 1'b1;
		tick(5);
		rd(IDX_EDGE_STATUS, 8'h01);
		chk("irq", 32'h1, 32'(irq));
		wr(IDX_EDGE_STATUS, 8'hfe);
		rd(IDX_EDGE_STATUS, 8'h01);
		wr(IDX_EDGE_STATUS, 8'hff);
		rd(IDX_EDGE_STATUS, 8'h00);
		chk("irqClear", 32'h0, 32'(irq));
		edgeInterruptPin0 <= 1'b0;
		// the clear lands on the edge at which the falling edge sets
		tick(1);
		wr(IDX_EDGE_STATUS, 8'h01);
		rd(IDX_EDGE_STATUS, 8'h01);
		wr(IDX_EDGE_STATUS, 8'h01);
		wr(IDX_EDGE_MASK, 8'h00);
		edgeInterruptPin1 <= 1'b1;
		tick(5);
		rd(IDX_EDGE_STATUS, 8'h02);
		chk("irqMasked", 32'h0, 32'(irq));
		edgeInterruptPin1 <= 1'b0;
		tick(5);
		wr(IDX_EDGE_STATUS, 8'h03);
		doReset();
		rd(IDX_WAKE_CTRL, WAKE_CTRL_RESET);
		rd(IDX_SCAN_CODE, SCAN_CODE_RESET);
		conclude();
	end
endmodule
`default_nettype wire
